//--- core/pvc_pkg.sv
// Package for the process-value input conditioning block.
// Assumes a 40 MHz clock and a 32-bit APB register port.
package pvc_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned SAMPLE_MS = 500;
   localparam int unsigned SAMPLE_CYCLES_DEF = CLK_HZ / 1000 * SAMPLE_MS;
   localparam int unsigned SAMPLE_TENTHS_S = 5;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_RANGE = 8'h00;
   localparam logic [7:0] OFS_UNIT = 8'h04;
   localparam logic [7:0] OFS_JCOMP = 8'h08;
   localparam logic [7:0] OFS_DROPOUT = 8'h0C;
   localparam logic [7:0] OFS_DECIMAL = 8'h10;
   localparam logic [7:0] OFS_SCALE_LO = 8'h14;
   localparam logic [7:0] OFS_SCALE_HI = 8'h18;
   localparam logic [7:0] OFS_GAIN = 8'h1C;
   localparam logic [7:0] OFS_OFFSET = 8'h20;
   localparam logic [7:0] OFS_LAG = 8'h24;
   localparam logic [7:0] OFS_PV = 8'h28;
   localparam logic [7:0] OFS_STATUS = 8'h2C;
   localparam logic [7:0] OFS_LIMITS = 8'h30;

   // ----------------------------------------------------------------
   // Reset values and legal ranges
   // ----------------------------------------------------------------
   localparam logic [7:0] RANGE_RST = 8'h01;
   localparam logic signed [31:0] DROPOUT_MAX = 32'sh0000_03E8;
   localparam logic signed [31:0] PCT_FULL = 32'sh0000_03E8;
   localparam logic signed [31:0] SCALE_MIN = -32'sh0000_07CF;
   localparam logic signed [31:0] SCALE_MAX = 32'sh0000_270F;
   localparam logic signed [31:0] SCALE_LO_RST = 32'sh0000_0000;
   localparam logic signed [31:0] SCALE_HI_RST = 32'sh0000_03E8;
   localparam logic signed [31:0] GAIN_MIN = 32'sh0000_0001;
   localparam logic signed [31:0] GAIN_MAX = 32'sh0000_270F;
   localparam logic signed [31:0] GAIN_RST = 32'sh0000_03E8;
   localparam logic signed [31:0] GAIN_UNITY = 32'sh0000_03E8;
   localparam logic signed [31:0] LAG_MAX = 32'sh0000_04B0;
   localparam logic [1:0] DEC_MAX_DC = 2'h3;
   localparam logic [1:0] DEC_MAX_TEMP = 2'h1;
   localparam logic [3:0] SQRT_TOP_BIT = 4'h9;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef logic signed [31:0] pvc_val_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pvc_apb_req_t;

   typedef struct packed {
      logic overRange;
      logic underRange;
      logic flash;
      logic sampleDone;
   } pvc_status_t;

   typedef struct packed {
      pvc_val_t lo;
      pvc_val_t hi;
   } pvc_range_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SQRT = 3'b001,
      ST_SCALE = 3'b010,
      ST_CORR = 3'b011,
      ST_FILT = 3'b100,
      ST_HOLD = 3'b101
   } pvc_state_t;

endpackage

//--- core/pvc_input_conditioning.sv
// Process-value input conditioning chain with an APB register port.
// Assumes the digitiser delivers the reading as percent of range in
// tenths of a percent, synchronous to clk, and hold requests from DI.
//
// Operation
// R1: Unit select, TC/RTD only, 0=C 1=F.
// R2: TC junction compensation select, default internal.
// R3: DC square-root dropout, zero disables extraction.
// R4: Between dropout and 100 percent, take root.
// R5: Above zero below dropout, output zero.
// R6: At or outside 0..100 percent, pass through.
// R7: Decimal places 0..3, only where supported.
// R8: New decimal position propagates to PV settings.
// R9: DC scaling limits -1999..9999, default 0/1000.
// R10: TC/RTD limits come from range table.
// R11: Correct value as input times ratio plus bias.
// R12: First-order lag updated every half second.
// R13: Lag constant 0.1..120 s, zero bypasses.
// R14: Plain hold freezes the conditioned value.
// R15: Max hold takes only strictly larger samples.
// R16: Min hold takes only strictly smaller samples.
// R17: Any hold mode flashes the PV display.
// R18: Limits at -10 and 110 percent FS.
// R19: Clamp conditioned value within derived limits.
// R20: Alarm pre-correction value beyond derived limits.
// R21: Range code change loads its decimal default; a DC code keeps the current decimal_q.
// R22: Change to DC resets scaling to 0/1000.
// R23: Stages run in fixed order per sample.
// R24: Writes to unavailable parameters are ignored.
`timescale 1ns/1ps
module pvc_input_conditioning #(
   parameter int unsigned SAMPLE_CYCLES = pvc_pkg::SAMPLE_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic rst,
   input wire pvc_pkg::pvc_apb_req_t apbReq,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [15:0] rawPercent,
   input wire logic holdPlain,
   input wire logic holdMax,
   input wire logic holdMin,
   output logic signed [15:0] pvValue,
   output pvc_pkg::pvc_status_t pvStatus,
   output logic tempUnitSelect,
   output logic junctionCompSelect,
   output logic [1:0] decimalPosition,
   output logic decimalUpdate
);
   import pvc_pkg::*;

   // ----------------------------------------------------------------
   // Range table helpers
   // ----------------------------------------------------------------
   function automatic pvc_range_t rl(input int lo, input int hi);
      pvc_range_t r;
      r.lo = 32'(lo);
      r.hi = 32'(hi);
      return r;
   endfunction

   function automatic logic isTc(input logic [7:0] c);
      return (c >= 8'h01) && (c <= 8'h19);
   endfunction

   function automatic logic isRtd(input logic [7:0] c);
      return (c >= 8'h29) && (c <= 8'h44);
   endfunction

   function automatic logic isDc(input logic [7:0] c);
      return (c == 8'h54) || ((c >= 8'h56) && (c <= 8'h5A));
   endfunction

   // Whole-degree span of each temperature range, Celsius or Fahrenheit.
   function automatic pvc_range_t rangeTable(input logic [7:0] c,
                                             input logic f);
      pvc_range_t r;
      r = rl(0, 0);
      case (c)
         8'h01: r = f ? rl(-300, 2200) : rl(-200, 1200);
         8'h02: r = f ? rl(0, 2200) : rl(0, 1200);
         8'h03, 8'h09: r = f ? rl(0, 1500) : rl(0, 800);
         8'h04, 8'h0A, 8'h0D: r = f ? rl(0, 1100) : rl(0, 600);
         8'h05: r = f ? rl(0, 700) : rl(0, 400);
         8'h06, 8'h0B, 8'h0E, 8'h18: r = f ? rl(-300, 700) : rl(-200, 400);
         8'h0F, 8'h10: r = f ? rl(0, 3000) : rl(0, 1600);
         8'h11: r = f ? rl(0, 3300) : rl(0, 1800);
         8'h12, 8'h13: r = f ? rl(0, 2300) : rl(0, 1300);
         8'h14: r = f ? rl(0, 2400) : rl(0, 1400);
         8'h15: r = f ? rl(0, 4200) : rl(0, 2300);
         8'h19: r = f ? rl(-150, 1500) : rl(-100, 800);
         8'h29, 8'h2A: r = f ? rl(-300, 900) : rl(-200, 500);
         8'h2B, 8'h2C: r = f ? rl(-300, 400) : rl(-200, 200);
         8'h2D, 8'h2E: r = f ? rl(-150, 500) : rl(-100, 300);
         8'h33, 8'h34: r = f ? rl(-50, 400) : rl(-50, 200);
         8'h35, 8'h36: r = f ? rl(-50, 200) : rl(-50, 100);
         8'h3F, 8'h40: r = f ? rl(0, 400) : rl(0, 200);
         8'h43, 8'h44: r = f ? rl(0, 900) : rl(0, 500);
         default: r = rl(0, 0);
      endcase
      return r;
   endfunction

   // Ranges that accept one decimal place.
   function automatic logic dpCapable(input logic [7:0] c);
      case (c)
         8'h03, 8'h04, 8'h05, 8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0D, 8'h0E,
         8'h18, 8'h19, 8'h33, 8'h34, 8'h35, 8'h36, 8'h3F, 8'h40:
            return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic [1:0] dpDefault(input logic [7:0] c);
      return (isRtd(c) && dpCapable(c)) ? 2'h1 : 2'h0;
   endfunction

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   logic [7:0] range_q;
   logic unit_q;
   logic jcomp_q;
   pvc_val_t dropout_q;
   logic [1:0] decimal_q;
   pvc_val_t scaleLo_q;
   pvc_val_t scaleHi_q;
   pvc_val_t gain_q;
   pvc_val_t offset_q;
   pvc_val_t lag_q;
   logic decUpd_q;

   logic wrEn;
   logic isTemp;
   logic [7:0] wrCode;
   pvc_val_t wrVal;
   logic [1:0] decMax;

   assign wrEn = apbReq.psel & apbReq.penable & apbReq.pwrite;
   assign wrVal = apbReq.pwdata;
   assign wrCode = apbReq.pwdata[7:0];
   assign isTemp = isTc(range_q) | isRtd(range_q);
   assign decMax = isDc(range_q) ? DEC_MAX_DC : DEC_MAX_TEMP;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         range_q <= RANGE_RST;
         unit_q <= 1'b0; // R1
         jcomp_q <= 1'b0; // R2
         dropout_q <= '0; // R3
         decimal_q <= 2'h0; // R7
         scaleLo_q <= SCALE_LO_RST; // R9
         scaleHi_q <= SCALE_HI_RST; // R9
         gain_q <= GAIN_RST; // R11
         offset_q <= '0;
         lag_q <= '0; // R13
         decUpd_q <= 1'b0;
      end else begin
         decUpd_q <= 1'b0;
         if (wrEn) begin
            case (apbReq.paddr)
               OFS_RANGE: begin
                  if (isTc(wrCode) | isRtd(wrCode) | isDc(wrCode)) begin
                     range_q <= wrCode;
                     if (isDc(wrCode)) begin
                        scaleLo_q <= SCALE_LO_RST; // R22
                        scaleHi_q <= SCALE_HI_RST; // R22
                     end else begin
                        decimal_q <= dpDefault(wrCode); // R21
                        decUpd_q <= 1'b1; // R8
                     end
                  end
               end
               OFS_UNIT: if (isTemp) begin
                  unit_q <= apbReq.pwdata[0]; // R1 R24
               end
               OFS_JCOMP: if (isTc(range_q)) begin
                  jcomp_q <= apbReq.pwdata[0]; // R2 R24
               end
               OFS_DROPOUT: begin
                  if (isDc(range_q) && wrVal >= 0 && wrVal <= DROPOUT_MAX)
                  begin
                     dropout_q <= wrVal; // R3 R24
                  end
               end
               OFS_DECIMAL: begin
                  if ((isDc(range_q) || dpCapable(range_q)) &&
                      apbReq.pwdata[31:2] == '0 &&
                      apbReq.pwdata[1:0] <= decMax) begin
                     decimal_q <= apbReq.pwdata[1:0]; // R7 R24
                     decUpd_q <= 1'b1; // R8
                  end
               end
               OFS_SCALE_LO: begin
                  if (isDc(range_q) && wrVal >= SCALE_MIN &&
                      wrVal <= SCALE_MAX) begin
                     scaleLo_q <= wrVal; // R9 R10 R24
                  end
               end
               OFS_SCALE_HI: begin
                  if (isDc(range_q) && wrVal >= SCALE_MIN &&
                      wrVal <= SCALE_MAX) begin
                     scaleHi_q <= wrVal; // R9 R10 R24
                  end
               end
               OFS_GAIN: begin
                  if (wrVal >= GAIN_MIN && wrVal <= GAIN_MAX) begin
                     gain_q <= wrVal; // R11
                  end
               end
               OFS_OFFSET: begin
                  if (wrVal >= SCALE_MIN && wrVal <= SCALE_MAX) begin
                     offset_q <= wrVal; // R11
                  end
               end
               OFS_LAG: begin
                  if (wrVal >= 0 && wrVal <= LAG_MAX) begin
                     lag_q <= wrVal; // R13
                  end
               end
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Range limits
   // ----------------------------------------------------------------
   pvc_range_t tbl;
   pvc_val_t baseLo;
   pvc_val_t baseHi;
   pvc_val_t span;
   pvc_val_t limLo;
   pvc_val_t limHi;

   always_comb begin
      tbl = rangeTable(range_q, unit_q);
      if (isDc(range_q)) begin
         baseLo = scaleLo_q; // R9
         baseHi = scaleHi_q;
      end else if (decimal_q != 2'h0) begin
         baseLo = tbl.lo * 32'sd10; // R10
         baseHi = tbl.hi * 32'sd10;
      end else begin
         baseLo = tbl.lo; // R10
         baseHi = tbl.hi;
      end
   end

   assign span = baseHi - baseLo;
   assign limLo = baseLo - span / 32'sd10; // R18
   assign limHi = baseHi + span / 32'sd10; // R18

   // ----------------------------------------------------------------
   // Sample timer
   // ----------------------------------------------------------------
   logic [31:0] tick_q;
   logic tick;

   assign tick = (tick_q == 32'(SAMPLE_CYCLES - 1));

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick ? '0 : tick_q + 32'h1; // R12
      end
   end

   // ----------------------------------------------------------------
   // Conditioning pipeline
   // ----------------------------------------------------------------
   // Stages take one clock each except ST_SQRT, which takes ten, so a sample ends long before the next.
   pvc_state_t state_q;
   pvc_val_t x_q;
   pvc_val_t y_q;
   pvc_val_t scaled_q;
   pvc_val_t corr_q;
   pvc_val_t filt_q;
   pvc_val_t hold_q;
   pvc_val_t pv_q;
   logic [19:0] rad_q;
   logic [9:0] root_q;
   logic [3:0] bit_q;
   logic primed_q;
   logic overR_q;
   logic underR_q;
   logic done_q;

   logic [9:0] trial;
   logic rootFits;
   pvc_val_t rawExt;
   pvc_val_t filtNext;
   pvc_val_t holdNext;
   logic anyHold;

   assign rawExt = 32'(rawPercent);
   assign trial = root_q | (10'h001 << bit_q);
   assign rootFits = (20'(trial) * 20'(trial)) <= rad_q;
   assign anyHold = holdPlain | holdMax | holdMin;

   always_comb begin
      if (!primed_q || lag_q == '0) begin
         filtNext = corr_q; // R13
      end else begin
         filtNext = filt_q + ((corr_q - filt_q) * pvc_val_t'(SAMPLE_TENTHS_S))
                    / (lag_q + pvc_val_t'(SAMPLE_TENTHS_S)); // R12
      end
   end

   always_comb begin
      holdNext = filt_q;
      if (!primed_q) begin
         holdNext = filt_q;
      end else if (holdPlain) begin
         holdNext = hold_q; // R14
      end else if (holdMax) begin
         holdNext = (filt_q > hold_q) ? filt_q : hold_q; // R15
      end else if (holdMin) begin
         holdNext = (filt_q < hold_q) ? filt_q : hold_q; // R16
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         x_q <= '0;
         y_q <= '0;
         scaled_q <= '0;
         corr_q <= '0;
         filt_q <= '0;
         hold_q <= '0;
         pv_q <= '0;
         rad_q <= '0;
         root_q <= '0;
         bit_q <= '0;
         primed_q <= 1'b0;
         overR_q <= 1'b0;
         underR_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (tick) begin
                  x_q <= rawExt;
                  if (isDc(range_q) && dropout_q != '0 &&
                      rawExt > 0 && rawExt < PCT_FULL) begin
                     if (rawExt < dropout_q) begin
                        y_q <= '0; // R5
                        state_q <= ST_SCALE;
                     end else begin
                        rad_q <= 20'(rawExt * PCT_FULL); // R4
                        root_q <= '0;
                        bit_q <= SQRT_TOP_BIT;
                        state_q <= ST_SQRT;
                     end
                  end else begin
                     y_q <= rawExt; // R3 R6
                     state_q <= ST_SCALE;
                  end
               end
            end
            ST_SQRT: begin
               if (rootFits) begin
                  root_q <= trial;
               end
               if (bit_q == 4'h0) begin
                  y_q <= 32'(rootFits ? trial : root_q); // R4
                  state_q <= ST_SCALE; // R23
               end else begin
                  bit_q <= bit_q - 4'h1;
               end
            end
            ST_SCALE: begin
               scaled_q <= baseLo + (span * y_q) / PCT_FULL; // R9 R23
               state_q <= ST_CORR;
            end
            ST_CORR: begin
               overR_q <= scaled_q > limHi; // R20
               underR_q <= scaled_q < limLo; // R20
               corr_q <= (scaled_q * gain_q) / GAIN_UNITY + offset_q; // R11
               state_q <= ST_FILT; // R23
            end
            ST_FILT: begin
               filt_q <= filtNext; // R12 R13
               state_q <= ST_HOLD; // R23
            end
            ST_HOLD: begin
               hold_q <= holdNext;
               primed_q <= 1'b1;
               if (holdNext > limHi) begin
                  pv_q <= limHi; // R19
               end else if (holdNext < limLo) begin
                  pv_q <= limLo; // R19
               end else begin
                  pv_q <= holdNext;
               end
               done_q <= 1'b1;
               state_q <= ST_IDLE; // R23
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign pvValue = pv_q[15:0];
   assign pvStatus.overRange = overR_q;
   assign pvStatus.underRange = underR_q;
   assign pvStatus.flash = anyHold; // R17
   assign pvStatus.sampleDone = done_q;
   assign tempUnitSelect = unit_q;
   assign junctionCompSelect = jcomp_q;
   assign decimalPosition = decimal_q; // R8
   assign decimalUpdate = decUpd_q; // R8

   // ----------------------------------------------------------------
   // APB read side
   // ----------------------------------------------------------------
   // Zero-wait slave, since all registers are flops.
   logic known;

   assign pready = 1'b1;

   always_comb begin
      known = 1'b1;
      prdata = '0;
      case (apbReq.paddr)
         OFS_RANGE: prdata = {24'h00_0000, range_q};
         OFS_UNIT: prdata = {31'h0000_0000, unit_q};
         OFS_JCOMP: prdata = {31'h0000_0000, jcomp_q};
         OFS_DROPOUT: prdata = dropout_q;
         OFS_DECIMAL: prdata = {30'h0000_0000, decimal_q};
         OFS_SCALE_LO: prdata = baseLo; // R10
         OFS_SCALE_HI: prdata = baseHi; // R10
         OFS_GAIN: prdata = gain_q;
         OFS_OFFSET: prdata = offset_q;
         OFS_LAG: prdata = lag_q;
         OFS_PV: prdata = pv_q;
         OFS_STATUS: prdata = {28'h000_0000, overR_q, underR_q, anyHold,
                               primed_q};
         OFS_LIMITS: prdata = {limHi[15:0], limLo[15:0]};
         default: known = 1'b0;
      endcase
      if (!(apbReq.psel && apbReq.penable && !apbReq.pwrite)) begin
         prdata = '0;
      end
   end

   assign pslverr = apbReq.psel & apbReq.penable & ~known;

endmodule

//--- testbench/pvc_sensor_model.sv
// Sensor front-end model: reading in tenths of a percent.
// Assumes the bench sets the analog level between sample ticks.
`timescale 1ns/1ps
module pvc_sensor_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic signed [15:0] level,
   output logic signed [15:0] rawPercent
);
   // Registered, so a new level shows one edge later.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rawPercent <= 16'sh0000;
      end else begin
         rawPercent <= level;
      end
   end
endmodule

//--- testbench/pvc_monitor.sv
// Concurrent checks on the ports of the conditioning block.
// Assumes pvc_pkg is compiled first.
`timescale 1ns/1ps
module pvc_monitor #(
   parameter int unsigned SAMPLE_CYCLES = 20
) (
   input wire logic clk,
   input wire logic rst,
   input wire pvc_pkg::pvc_apb_req_t apbReq,
   input wire logic holdPlain,
   input wire logic holdMax,
   input wire logic holdMin,
   input wire logic signed [15:0] pvValue,
   input wire pvc_pkg::pvc_status_t pvStatus,
   input wire logic tempUnitSelect,
   input wire logic junctionCompSelect,
   input wire logic [1:0] decimalPosition,
   input wire logic decimalUpdate
);
   import pvc_pkg::*;
   logic wrAcc, wrUnit, wrJcomp, wrDec;
   int unsigned gap_q;
   assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
   assign wrUnit = wrAcc && apbReq.paddr == OFS_UNIT;
   assign wrJcomp = wrAcc && apbReq.paddr == OFS_JCOMP;
   assign wrDec = wrAcc && (apbReq.paddr == OFS_DECIMAL ||
      apbReq.paddr == OFS_RANGE);
   // Saturating gap counter, so a doubled sample tick cannot hide.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q <= '0;
      end else if (pvStatus.sampleDone) begin
         gap_q <= '0;
      end else if (gap_q < SAMPLE_CYCLES) begin
         gap_q <= gap_q + 1;
      end
   end
   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence s_dec_pulse;
      decimalUpdate ##1 !decimalUpdate;
   endsequence
   sequence s_held(h);
      h [*8] ##0 pvStatus.sampleDone;
   endsequence
   a_flash_any_hold:
   assert property (pvStatus.flash == (holdPlain || holdMax || holdMin))
      else $error("flash wrong");
   a_unit_by_write:
   assert property ($changed(tempUnitSelect) |-> $past(wrUnit))
      else $error("unit moved");
   a_jcomp_by_write:
   assert property ($changed(junctionCompSelect) |-> $past(wrJcomp))
      else $error("jcomp moved");
   a_decimal_by_write:
   assert property ($changed(decimalPosition) |-> $past(wrDec))
      else $error("decimal moved");
   a_decimal_pulse:
   assert property ($changed(decimalPosition) |-> ##[0:1] s_dec_pulse)
      else $error("no decimal pulse");
   a_alarm_exclusive:
   assert property (!(pvStatus.overRange && pvStatus.underRange))
      else $error("both alarms");
   a_alarm_per_sample:
   assert property ($changed(pvStatus.overRange) ||
      $changed(pvStatus.underRange) |-> ##[0:4] pvStatus.sampleDone)
      else $error("alarm off sample");
   a_sample_period:
   assert property (pvStatus.sampleDone |-> gap_q + 11 >= SAMPLE_CYCLES)
      else $error("sample too soon");
   a_hold_plain:
   assert property (s_held(holdPlain) |-> $stable(pvValue))
      else $error("hold moved");
   a_hold_max:
   assert property (s_held(holdMax) ##0 !holdPlain |->
      pvValue >= $past(pvValue)) else $error("max hold value fell");
   a_hold_min:
   assert property (s_held(holdMin) ##0 !holdPlain && !holdMax |->
      pvValue <= $past(pvValue)) else $error("min hold value rose");
endmodule
bind pvc_input_conditioning pvc_monitor #(
   .SAMPLE_CYCLES(SAMPLE_CYCLES)
) mon (.*);

//--- testbench/tb.sv
// Self-checking bench for the process-value conditioning block.
// Assumes the package, model and monitor compile first.
`timescale 1ns/1ps
module tb;
   import pvc_pkg::*;
   localparam int unsigned SC = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   pvc_apb_req_t apbReq = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, sErr, tempUnitSelect, junctionCompSelect;
   logic decimalUpdate;
   logic holdPlain = 1'b0, holdMax = 1'b0, holdMin = 1'b0;
   logic signed [15:0] rawPercent, pvValue;
   logic signed [15:0] level = 16'sh0000;
   pvc_status_t pvStatus;
   logic [1:0] decimalPosition;
   int errTotal = 0, testsRun = 0;
   int seed = 32'hEE6E;
   int drop = 0, gain = 1000, ofs = 0, lag = 0, lo = 0, hi = 1000;
   int prevF = 0, held = 0;
   logic [7:0] rAdr [8] = '{OFS_UNIT, OFS_JCOMP, OFS_DROPOUT, OFS_DECIMAL,
      OFS_GAIN, OFS_OFFSET, OFS_LAG, OFS_RANGE};
   int rVal [8] = '{0, 0, 0, 0, 1000, 0, 0, 1};
   int sq [8] = '{0, 50, 99, 100, 490, 999, 1000, 1200};
   pvc_sensor_model adc (.*);
   pvc_input_conditioning #(.SAMPLE_CYCLES(SC)) dut (.*);
   initial begin
      forever #12.5 clk = ~clk;
   end
   // ---------------------------------------------------------------
   // Bus and model tasks
   // ---------------------------------------------------------------
   task automatic testDone();
      $display("Checks %0d errors %0d", testsRun, errTotal);
      if (errTotal == 0 && testsRun > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) begin
         errTotal++;
         $display("ERROR %0t got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      errTotal++;
      $display("ERROR %0t timeout", $time);
      testDone();
   endtask
   // Called just after a rising edge; leaves one idle cycle behind.
   task automatic apb(input logic [7:0] a, input logic [31:0] d,
      input logic wr = 1'b1);
      int n;
      n = 0;
      apbReq <= '{1'b1, 1'b0, wr, a, d};
      @(posedge clk);
      apbReq.penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      rd = prdata;
      sErr = pslverr;
      apbReq <= '0;
      @(posedge clk);
   endtask
   task automatic waitDone();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pvStatus.sampleDone !== 1'b1 && n < 4 * SC);
      if (n >= 4 * SC) tmo();
   endtask
   function automatic int isqrt(input int v);
      int r;
      r = 0;
      while ((r + 1) * (r + 1) <= v) r++;
      return r;
   endfunction
   // Starts just after a finished sample.
   task automatic step(input int raw, input logic [2:0] hold);
      int y, s, f, ll, hl;
      {holdPlain, holdMax, holdMin} <= hold;
      level <= raw[15:0];
      waitDone();
      y = raw;
      ll = lo - (hi - lo) / 10;
      hl = hi + (hi - lo) / 10;
      if (drop != 0 && raw > 0 && raw < drop) begin
         y = 0;
      end else if (drop != 0 && raw >= drop && raw < 1000) begin
         y = isqrt(raw * 1000);
      end
      s = lo + (hi - lo) * y / 1000;
      f = s * gain / 1000 + ofs;
      if (lag != 0) f = prevF + (f - prevF) * 5 / (lag + 5);
      prevF = f;
      if (!(hold[2] || hold[1] && f <= held || hold[0] && f >= held))
         held = f;
      f = held > hl ? hl : (held < ll ? ll : held);
      chk(pvValue, f);
      chk(pvStatus.overRange, s > hl);
      chk(pvStatus.underRange, s < ll);
      chk(pvStatus.flash, |hold);
   endtask
   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rAdr[i]) begin
         apb(rAdr[i], '0, 1'b0);
         chk(rd, rVal[i]);
      end
      apb(8'hFC, '0, 1'b0);
      chk(sErr, 1);
      apb(OFS_SCALE_HI, 32'h7D0);
      apb(OFS_SCALE_HI, '0, 1'b0);
      chk(rd, 1200);
      apb(OFS_DECIMAL, 32'h1);
      chk(decimalPosition, 0);
      apb(OFS_UNIT, 32'h1);
      apb(OFS_JCOMP, 32'h1);
      chk(tempUnitSelect, 1);
      chk(junctionCompSelect, 1);
      apb(OFS_RANGE, 32'h33);
      chk(decimalPosition, 1);
      apb(OFS_RANGE, 32'h54);
      apb(OFS_UNIT, '0);
      chk(tempUnitSelect, 1);
      apb(OFS_DECIMAL, 32'h3);
      apb(OFS_DECIMAL, 32'h4);
      chk(decimalPosition, 3);
      $display("Registers done");
      lo = -1999;
      hi = 9999;
      apb(OFS_SCALE_LO, lo);
      apb(OFS_SCALE_HI, hi);
      apb(OFS_SCALE_HI, 32'h2710);
      apb(OFS_SCALE_HI, '0, 1'b0);
      chk(rd, hi);
      waitDone();
      for (int i = 0; i < 6; i++) step($random(seed) % 700 + 500, 3'b000);
      step(1200, 3'b000);
      $display("Scaling done");
      apb(OFS_RANGE, 32'h56);
      lo = 0;
      hi = 1000;
      apb(OFS_SCALE_LO, '0, 1'b0);
      chk(rd, lo);
      drop = 100;
      apb(OFS_DROPOUT, drop);
      foreach (sq[i]) step(sq[i], 3'b000);
      $display("Root done");
      drop = 0;
      apb(OFS_DROPOUT, '0);
      for (int i = 0; i < 4; i++) begin
         gain = 1 + {$random(seed)} % 9999;
         ofs = {$random(seed)} % 11999 - 1999;
         apb(OFS_GAIN, gain);
         apb(OFS_OFFSET, ofs);
         step({$random(seed)} % 1001, 3'b000);
      end
      $display("Gain done");
      gain = 1000;
      ofs = 0;
      lag = 5;
      apb(OFS_GAIN, gain);
      apb(OFS_OFFSET, '0);
      apb(OFS_LAG, lag);
      step(400, 3'b000);
      step(400, 3'b000);
      step(-100, 3'b000);
      lag = 0;
      apb(OFS_LAG, '0);
      $display("Lag done");
      step(300, 3'b000);
      step(500, 3'b010);
      step(200, 3'b010);
      step(100, 3'b001);
      step(400, 3'b001);
      step(700, 3'b100);
      step(700, 3'b000);
      $display("Hold done");
      testDone();
   end
endmodule
